/* obcr_map.vh */
// Register offsets, field positions, reset values and timing counts for the option config block
`ifndef OBCR_MAP_VH
`define OBCR_MAP_VH

// Register byte offsets
`define OBCR_OPT_OFF 12'h000
`define OBCR_STAT_OFF 12'h004
`define OBCR_PIN_OFF 12'h008
`define OBCR_PULLUP_OFF 12'h00c
`define OBCR_LVD_OFF 12'h010
`define OBCR_IRQ_STAT_OFF 12'h014
`define OBCR_IRQ_MASK_OFF 12'h018

// Option word fields
`define OBCR_OPT_CLK_LSB 0
`define OBCR_OPT_CLK_MSB 1
`define OBCR_OPT_RPME_BIT 2
`define OBCR_OPT_LSRUN_BIT 3
`define OBCR_OPT_WAIT_LSB 4
`define OBCR_OPT_WAIT_MSB 5
`define OBCR_OPT_RESET 8'h04

// Clock source codes
`define OBCR_CLK_XTAL 2'h0
`define OBCR_CLK_EXT 2'h1
`define OBCR_CLK_HSINT 2'h2

// Pull-up register bit for the reset-shared port
`define OBCR_PU_RST_BIT 4

// LVD control register fields
`define OBCR_LVD_EN_BIT 0
`define OBCR_LVD_IRQMODE_BIT 1

// Interrupt status bits
`define OBCR_IRQ_LVD_BIT 0
`define OBCR_IRQ_READY_BIT 1

// Stabilisation waits in microseconds per wait code, at 100 MHz
`define OBCR_CLK_MHZ 100
`define OBCR_WAIT0_US 64
`define OBCR_WAIT1_US 128
`define OBCR_WAIT2_US 256
`define OBCR_WAIT3_US 512
`define OBCR_WAIT0_CYC (`OBCR_WAIT0_US * `OBCR_CLK_MHZ)
`define OBCR_WAIT1_CYC (`OBCR_WAIT1_US * `OBCR_CLK_MHZ)
`define OBCR_WAIT2_CYC (`OBCR_WAIT2_US * `OBCR_CLK_MHZ)
`define OBCR_WAIT3_CYC (`OBCR_WAIT3_US * `OBCR_CLK_MHZ)

`endif

/* obcr_pin_mux.v */
// Shared clock pin assignment from the latched clock source and variant
`timescale 1ns/1ps
module obcr_pin_mux (
	input wire [1:0] clk_src, // Latched clock source
	input wire variant_ext_only, // 1: only an external clock pin
	output wire osc_in_is_clock, // Oscillator-in pin owned by clock
	output wire osc_out_is_clock, // Oscillator-out pin owned by clock
	output wire port_a_enable, // Port/analog A usable
	output wire port_b_enable, // Port/analog B usable
	output wire port_c_enable, // Port C usable
	output wire ext_clk_pin_is_clock // External clock pin owned by clock
);
`include "obcr_map.vh"

	wire is_xtal;
	wire is_ext;

	assign is_xtal = (clk_src == `OBCR_CLK_XTAL) && !variant_ext_only;
	assign is_ext = (clk_src == `OBCR_CLK_EXT);

	assign osc_in_is_clock = is_xtal || (is_ext && !variant_ext_only);
	assign osc_out_is_clock = is_xtal;
	// Both pins free only with the internal oscillator or the unused source code 3
	assign port_a_enable = !variant_ext_only && !osc_in_is_clock;
	assign port_b_enable = !variant_ext_only && !osc_out_is_clock;
	assign port_c_enable = !(is_ext && !variant_ext_only);
	assign ext_clk_pin_is_clock = variant_ext_only && is_ext;
endmodule // obcr_pin_mux

/* obcr_ctrl.v */
// Option-driven clock source, reset pin and LVD configuration with APB access
//
// Added by the designer: the APB register port and the register addresses.
`timescale 1ns/1ps
// Header comes first so the option reset value is known in the parameter list
`include "obcr_map.vh"
module obcr_ctrl #(
	parameter VARIANT_EXT_ONLY = 0,
	parameter [7:0] OPT_DEFAULT = `OBCR_OPT_RESET
) (
	input wire pclk, // APB clock, 100 MHz
	input wire presetn, // Async reset, active low
	input wire psel, // APB select
	input wire penable, // APB enable
	input wire pwrite, // APB direction
	input wire [11:0] paddr, // APB byte address
	input wire [31:0] pwdata, // APB write data
	output wire [31:0] prdata, // APB read data
	output wire pready, // APB ready
	output wire pslverr, // APB error
	input wire [7:0] option_byte, // Nonvolatile option setting
	input wire reset_pin_in, // Level on the reset-shared pin
	input wire lvd_below, // Supply below detection level
	input wire wdt_sel_lsosc, // Software choice of watchdog clock
	output reg sys_reset_n, // Internal system reset, active low
	output reg clock_ready, // System clock usable
	output reg [1:0] clk_src, // Latched clock source
	output reg wdt_clk_lsosc, // Watchdog counts low-speed clock
	output reg reset_shared_input_port, // Reset pin value in port mode
	output reg reset_pin_pullup_en, // Pull-up on reset-shared pin
	output wire osc_in_is_clock, // Oscillator-in pin owned by clock
	output wire osc_out_is_clock, // Oscillator-out pin owned by clock
	output wire port_a_enable, // Port/analog A usable
	output wire port_b_enable, // Port/analog B usable
	output wire port_c_enable, // Port C usable
	output wire ext_clk_pin_is_clock, // External clock pin owned by clock
	output wire lvd_irq, // LVD interrupt request pulse
	output wire irq // Combined interrupt, level
);

	localparam ST_HOLD = 2'd0;
	localparam [31:0] WAIT0_LEN = `OBCR_WAIT0_CYC;
	localparam [31:0] WAIT1_LEN = `OBCR_WAIT1_CYC;
	localparam [31:0] WAIT2_LEN = `OBCR_WAIT2_CYC;
	localparam [31:0] WAIT3_LEN = `OBCR_WAIT3_CYC;
	localparam ST_READ = 2'd1;
	localparam ST_WAIT = 2'd2;
	localparam ST_RUN = 2'd3;

	reg [1:0] state_reg;
	reg [7:0] opt_reg;
	reg [16:0] wait_cnt_reg;
	reg [7:0] pullup_reg;
	reg [1:0] lvd_ctl_reg;
	reg [1:0] irq_stat_reg;
	reg [1:0] irq_mask_reg;
	reg lvd_below_reg;
	reg lvd_reset_reg;
	reg [31:0] rdata_reg;
	reg [16:0] wait_len;
	wire rst_pin_mode;
	wire ls_unstoppable;
	wire lvd_cross;
	wire wr_en;
	wire rd_en;
	wire addr_ok;
	wire ready_evt;

	assign rst_pin_mode = opt_reg[`OBCR_OPT_RPME_BIT];
	assign ls_unstoppable = opt_reg[`OBCR_OPT_LSRUN_BIT];

	////////////////////////////////////////////////////////////////////////////
	// APB slave: zero wait states, unmapped address answers with pslverr

	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && !penable && !pwrite;
	assign addr_ok = (paddr == `OBCR_OPT_OFF) || (paddr == `OBCR_STAT_OFF) ||
		(paddr == `OBCR_PIN_OFF) || (paddr == `OBCR_PULLUP_OFF) ||
		(paddr == `OBCR_LVD_OFF) || (paddr == `OBCR_IRQ_STAT_OFF) ||
		(paddr == `OBCR_IRQ_MASK_OFF);
	assign pready = 1'b1;
	assign pslverr = psel && penable && !addr_ok;
	assign prdata = rdata_reg;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata_reg <= 32'h0000_0000;
		end else if (rd_en) begin
			case (paddr)
				`OBCR_OPT_OFF: rdata_reg <= {24'h00_0000, opt_reg};
				`OBCR_STAT_OFF: rdata_reg <= {26'h000_0000, wdt_clk_lsosc, lvd_below_reg,
					clk_src, clock_ready, sys_reset_n};
				`OBCR_PIN_OFF: rdata_reg <= {25'h000_0000, reset_shared_input_port,
					ext_clk_pin_is_clock, port_c_enable, port_b_enable, port_a_enable,
					osc_out_is_clock, osc_in_is_clock};
				`OBCR_PULLUP_OFF: rdata_reg <= {24'h00_0000, pullup_reg};
				`OBCR_LVD_OFF: rdata_reg <= {30'h0000_0000, lvd_ctl_reg};
				`OBCR_IRQ_STAT_OFF: rdata_reg <= {30'h0000_0000, irq_stat_reg};
				`OBCR_IRQ_MASK_OFF: rdata_reg <= {30'h0000_0000, irq_mask_reg};
				default: rdata_reg <= 32'h0000_0000;
			endcase
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pullup_reg <= 8'h00;
			lvd_ctl_reg <= 2'h0;
			irq_mask_reg <= 2'h0;
		end else if (wr_en) begin
			case (paddr)
				`OBCR_PULLUP_OFF: pullup_reg <= pwdata[7:0];
				`OBCR_LVD_OFF: lvd_ctl_reg <= pwdata[1:0];
				`OBCR_IRQ_MASK_OFF: irq_mask_reg <= pwdata[1:0];
				default: pullup_reg <= pullup_reg;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Start-up sequence

	always @* begin
		case (opt_reg[`OBCR_OPT_WAIT_MSB:`OBCR_OPT_WAIT_LSB])
			2'h0: wait_len = WAIT0_LEN[16:0];
			2'h1: wait_len = WAIT1_LEN[16:0];
			2'h2: wait_len = WAIT2_LEN[16:0];
			default: wait_len = WAIT3_LEN[16:0];
		endcase
	end

	// Option is sampled once on each pass through ST_READ, after every reset, so the clock and pin setup
	// cannot shift under running software
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= ST_HOLD;
			opt_reg <= `OBCR_OPT_RESET;
			clk_src <= `OBCR_CLK_HSINT;
			wait_cnt_reg <= 17'h0_0000;
			sys_reset_n <= 1'b0;
			clock_ready <= 1'b0;
		end else begin
			case (state_reg)
				ST_HOLD: begin
					// Pin low before the option is read keeps the part in reset
					if (reset_pin_in) begin
						state_reg <= ST_READ;
					end
				end
				ST_READ: begin
					if (!reset_pin_in) begin
						state_reg <= ST_HOLD;
					end else begin
						opt_reg <= option_byte;
						clk_src <= option_byte[`OBCR_OPT_CLK_MSB:`OBCR_OPT_CLK_LSB];
						wait_cnt_reg <= 17'h0_0000;
						state_reg <= ST_WAIT;
					end
				end
				ST_WAIT: begin
					// Wait applies to the crystal only
					if (clk_src != `OBCR_CLK_XTAL || VARIANT_EXT_ONLY != 0 ||
						wait_cnt_reg >= wait_len - 17'h0_0001) begin
						state_reg <= ST_RUN;
						clock_ready <= 1'b1;
						sys_reset_n <= 1'b1;
					end else begin
						wait_cnt_reg <= wait_cnt_reg + 17'h0_0001;
					end
				end
				ST_RUN: begin
					// Pin as reset re-enters reset; LVD reset mode does too
					if ((rst_pin_mode && !reset_pin_in) || lvd_reset_reg) begin
						state_reg <= ST_HOLD;
						sys_reset_n <= 1'b0;
						clock_ready <= 1'b0;
					end
				end
				default: state_reg <= ST_HOLD;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Reset pin port mode and watchdog clock

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			reset_shared_input_port <= 1'b0;
			reset_pin_pullup_en <= 1'b1;
			wdt_clk_lsosc <= 1'b1;
		end else begin
			if (rst_pin_mode || state_reg != ST_RUN) begin
				reset_shared_input_port <= 1'b0;
				reset_pin_pullup_en <= 1'b1;
			end else begin
				reset_shared_input_port <= reset_pin_in;
				reset_pin_pullup_en <= pullup_reg[`OBCR_PU_RST_BIT];
			end
			wdt_clk_lsosc <= ls_unstoppable | wdt_sel_lsosc;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Low-voltage detector: both directions of crossing are events

	assign lvd_cross = lvd_ctl_reg[`OBCR_LVD_EN_BIT] && (lvd_below != lvd_below_reg);
	assign lvd_irq = lvd_cross && lvd_ctl_reg[`OBCR_LVD_IRQMODE_BIT];
	assign ready_evt = (state_reg == ST_WAIT) && (clk_src != `OBCR_CLK_XTAL ||
		VARIANT_EXT_ONLY != 0 || wait_cnt_reg >= wait_len - 17'h0_0001);

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lvd_below_reg <= 1'b0;
			lvd_reset_reg <= 1'b0;
		end else begin
			lvd_below_reg <= lvd_below;
			// Reset re-entered from ST_RUN while below; request clears one cycle after lvd_below falls
			lvd_reset_reg <= lvd_ctl_reg[`OBCR_LVD_EN_BIT] &&
				!lvd_ctl_reg[`OBCR_LVD_IRQMODE_BIT] && lvd_below;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Interrupt status, set wins over write-one-to-clear

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat_reg <= 2'h0;
		end else begin
			irq_stat_reg <= (irq_stat_reg &
				~((wr_en && paddr == `OBCR_IRQ_STAT_OFF) ? pwdata[1:0] : 2'h0)) |
				{ready_evt, lvd_irq};
		end
	end

	assign irq = |(irq_stat_reg & irq_mask_reg);

	obcr_pin_mux u_pin_mux (
		.clk_src(clk_src),
		.variant_ext_only(VARIANT_EXT_ONLY != 0),
		.osc_in_is_clock(osc_in_is_clock),
		.osc_out_is_clock(osc_out_is_clock),
		.port_a_enable(port_a_enable),
		.port_b_enable(port_b_enable),
		.port_c_enable(port_c_enable),
		.ext_clk_pin_is_clock(ext_clk_pin_is_clock)
	);
endmodule // obcr_ctrl

/* obcr_ext_model.sv */
// Far-side model: reset-shared pin and supply level
`timescale 1ns/1ps
module obcr_ext_model (
	input wire pclk, // clock
	input wire pin_low, // pull pin low
	input wire dip, // supply dips
	output reg reset_pin_in = 1'h1, // pin level
	output reg lvd_below = 1'h0 // below level
);
	// Pin has a pull-up, so a released pin reads high
	always @(posedge pclk) begin
		reset_pin_in <= !pin_low;
		lvd_below <= dip;
	end
endmodule // obcr_ext_model

/* obcr_ctrl_props.sv */
// Checker for the option-driven clock and reset block
`timescale 1ns/1ps
`include "obcr_map.vh"
module obcr_ctrl_props (
	input wire pclk, // clock
	input wire presetn, // reset
	input wire psel, // select
	input wire penable, // enable
	input wire pwrite, // write
	input wire [11:0] paddr, // address
	input wire [31:0] pwdata, // data
	input wire pready, // ready
	input wire pslverr, // error
	input wire [7:0] option_byte, // option
	input wire reset_pin_in, // pin
	input wire lvd_below, // supply low
	input wire sys_reset_n, // reset out
	input wire [1:0] clk_src, // source
	input wire wdt_clk_lsosc, // wdt clock
	input wire reset_pin_pullup_en, // pull-up
	input wire osc_in_is_clock, // osc in
	input wire osc_out_is_clock, // osc out
	input wire port_a_enable, // port a
	input wire port_b_enable, // port b
	input wire irq // interrupt
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	reg pu_reg, pu_seen_reg;
	wire src_ok = option_byte[1:0] != `OBCR_CLK_XTAL;
	// Mirror of the pull-up bit, valid once software wrote it
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pu_reg <= 1'h0;
			pu_seen_reg <= 1'h0;
		end else if (psel && penable && pwrite && paddr == `OBCR_PULLUP_OFF) begin
			pu_reg <= pwdata[`OBCR_PU_RST_BIT];
			pu_seen_reg <= 1'h1;
		end
	end
	property p_xtal_pins;
		clk_src == `OBCR_CLK_XTAL |-> osc_in_is_clock && osc_out_is_clock && !port_a_enable
			&& !port_b_enable;
	endproperty
	a_xtal_pins: assert property (p_xtal_pins) else $error("crystal pins not dedicated");
	property p_ext_pins;
		clk_src == `OBCR_CLK_EXT |-> osc_in_is_clock && !port_a_enable;
	endproperty
	a_ext_pins: assert property (p_ext_pins) else $error("external clock pin not taken");
	property p_int_pins;
		clk_src == `OBCR_CLK_HSINT |-> port_a_enable && port_b_enable && !osc_in_is_clock;
	endproperty
	a_int_pins: assert property (p_int_pins) else $error("oscillator pins not freed");
	property p_wdt_fix;
		sys_reset_n && option_byte[`OBCR_OPT_LSRUN_BIT] |-> wdt_clk_lsosc;
	endproperty
	a_wdt_fix: assert property (p_wdt_fix) else $error("watchdog clock not fixed");
	property p_no_wait;
		(reset_pin_in && !lvd_below && src_ok && !sys_reset_n) [*4] |-> 1'h0;
	endproperty
	a_no_wait: assert property (p_no_wait) else $error("wait on non-crystal source");
	property p_pin_hold;
		(!sys_reset_n && !reset_pin_in) [*2] |=> !sys_reset_n;
	endproperty
	a_pin_hold: assert property (p_pin_hold) else $error("reset left with pin low");
	property p_pullup;
		sys_reset_n && $past(sys_reset_n) && !option_byte[`OBCR_OPT_RPME_BIT] && $past(pu_seen_reg)
			|-> reset_pin_pullup_en == $past(pu_reg);
	endproperty
	a_pullup: assert property (p_pullup) else $error("pull-up not from its bit");
	property p_src_held;
		sys_reset_n && $past(sys_reset_n) |-> $stable(clk_src);
	endproperty
	a_src_held: assert property (p_src_held) else $error("clock source changed in run");
	property p_unmapped;
		psel && penable && paddr > `OBCR_IRQ_MASK_OFF |-> pslverr && pready;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
	c_xtal: cover property ($rose(sys_reset_n) && clk_src == `OBCR_CLK_XTAL);
	c_irq: cover property ($rose(irq));
	c_err: cover property (pslverr);
endmodule // obcr_ctrl_props
bind obcr_ctrl obcr_ctrl_props obcr_ctrl_props_i (.pclk, .presetn, .psel, .penable, .pwrite,
	.paddr, .pwdata, .pready, .pslverr, .option_byte, .reset_pin_in, .lvd_below, .sys_reset_n,
	.clk_src, .wdt_clk_lsosc, .reset_pin_pullup_en, .osc_in_is_clock, .osc_out_is_clock,
	.port_a_enable, .port_b_enable, .irq);

/* obcr_ctrl_test.sv */
// Self-checking bench for the option-driven clock and reset block
`timescale 1ns/1ps
`include "obcr_map.vh"
module obcr_ctrl_test;
	reg pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	reg wdt_sel_lsosc = 1'h0, pin_low = 1'h0, dip = 1'h0, er, v, w;
	reg [11:0] paddr = 12'h0;
	reg [31:0] pwdata = 32'h0, rd;
	reg [7:0] option_byte = `OBCR_OPT_RESET, opt;
	reg [1:0] src;
	wire [31:0] prdata;
	wire [1:0] clk_src;
	wire pready, pslverr, reset_pin_in, lvd_below, sys_reset_n, clock_ready, wdt_clk_lsosc;
	wire rsip, pu_en, lvd_irq, irq;
	integer failures = 0, checks = 0, c, k, i, np = 0;
	obcr_ctrl obcr_ctrl_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .option_byte, .reset_pin_in, .lvd_below, .wdt_sel_lsosc, .sys_reset_n,
		.clock_ready, .clk_src, .wdt_clk_lsosc, .reset_shared_input_port(rsip),
		.reset_pin_pullup_en(pu_en), .osc_in_is_clock(), .osc_out_is_clock(), .port_a_enable(),
		.port_b_enable(), .port_c_enable(), .ext_clk_pin_is_clock(), .lvd_irq, .irq);
	obcr_ext_model obcr_ext_model_i (.pclk, .pin_low, .dip, .reset_pin_in, .lvd_below);
	always #5 pclk = ~pclk;
	always @(posedge pclk) if (lvd_irq === 1'h1) np <= np + 1;
	////////////////////////////////////////////////////////////////////////
	task chk(input logic [31:0] s, input logic [31:0] e);
		checks = checks + 1;
		if (s !== e) begin
			failures = failures + 1;
			$display("Error %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		integer n;
		n = 0;
		psel <= 1'h1; pwrite <= wr; paddr <= a; pwdata <= d; penable <= 1'h0;
		@(posedge pclk) penable <= 1'h1;
		do begin @(posedge pclk); n = n + 1; end while (pready !== 1'h1 && n < 50);
		rd = prdata; er = pslverr; psel <= 1'h0; penable <= 1'h0;
		// One idle edge so a following call never re-drives psel in this step
		@(posedge pclk);
	endtask
	// Sampling on the falling edge keeps checks clear of the launch edge
	task wrel;
		c = 0;
		do begin @(negedge pclk); c = c + 1; end while (sys_reset_n !== 1'h1 && c < 7000);
		@(posedge pclk);
	endtask
	task rst(input logic [7:0] o, input logic p);
		presetn <= 1'h0; option_byte <= o; pin_low <= p;
		repeat (6) @(posedge pclk);
		presetn <= 1'h1;
		if (!p) wrel;
	endtask
	task summarize;
		$display("failures=%0d checks=%0d", failures, checks);
		if (failures == 0 && checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		#900000 failures = failures + 1;
		summarize;
	end
	////////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(32'h72ea3a63));
		for (k = 0; k < 3; k++) begin
			src = (k == 2) ? `OBCR_CLK_XTAL : k + 1;
			opt = {4'h0, 2'($urandom), src};
			w = $urandom;
			wdt_sel_lsosc <= w;
			rst(opt, 1'h0);
			if (k == 2) chk(c > `OBCR_WAIT0_CYC, 1);
			else chk(c, 4);
			apb(1'h0, `OBCR_PIN_OFF, 32'h0);
			chk(rd[3:0] & ((k == 0) ? 4'h5 : 4'hf), (k == 0) ? 4'h1 : (k == 1) ? 4'hc : 4'h3);
			chk(rd[5:4], (k == 0) ? 2'h0 : 2'h1);
			apb(1'h0, `OBCR_STAT_OFF, 32'h0);
			chk(rd[5:0], {opt[3] | w, 1'h0, src, 2'h3});
			v = $urandom;
			if (!opt[2]) apb(1'h1, `OBCR_PULLUP_OFF, {27'h0, v, 4'h0});
			pin_low <= 1'h1;
			repeat (3) @(posedge pclk);
			@(negedge pclk);
			if (!opt[2]) chk({sys_reset_n, rsip, pu_en}, {2'h2, v});
			else chk({sys_reset_n, pu_en}, 2'h1);
			@(posedge pclk) pin_low <= 1'h0;
			wrel;
			option_byte <= opt ^ 8'h03;
			repeat (4) @(posedge pclk);
			chk(clk_src, src);
		end
		rst(8'h05, 1'h1);
		repeat (20) @(posedge pclk);
		chk(sys_reset_n, 0);
		pin_low <= 1'h0;
		wrel;
		apb(1'h1, `OBCR_LVD_OFF, 32'h3);
		apb(1'h1, `OBCR_IRQ_MASK_OFF, 32'h1);
		apb(1'h1, `OBCR_IRQ_STAT_OFF, 32'h3);
		k = np;
		for (i = 0; i < 2; i++) begin
			dip <= 1'h1;
			repeat (4) @(posedge pclk);
			dip <= 1'h0;
			repeat (4) @(posedge pclk);
		end
		chk(np - k, 4);
		chk(irq, 1);
		apb(1'h1, `OBCR_IRQ_STAT_OFF, 32'h1);
		apb(1'h0, `OBCR_IRQ_STAT_OFF, 32'h0);
		chk({irq, rd[0]}, 0);
		apb(1'h1, `OBCR_IRQ_MASK_OFF, 32'h0);
		dip <= 1'h1;
		repeat (4) @(posedge pclk);
		apb(1'h0, `OBCR_IRQ_STAT_OFF, 32'h0);
		chk({irq, rd[0]}, 1);
		dip <= 1'h0;
		apb(1'h1, `OBCR_LVD_OFF, 32'h1);
		for (i = 0; i < 2; i++) begin
			dip <= 1'h1;
			repeat (4) @(posedge pclk);
			chk(sys_reset_n, 0);
			dip <= 1'h0;
			wrel;
		end
		apb(1'h1, `OBCR_OPT_OFF, 32'hff);
		apb(1'h0, `OBCR_OPT_OFF, 32'h0);
		chk(rd, 32'h05);
		apb(1'h0, 12'h0f0, 32'h0);
		chk(er, 1);
		chk(rd, 0);
		summarize;
	end
endmodule // obcr_ctrl_test
